// ### hw/ppi_host_pkg.sv
package ppi_host_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int T_ADDR_SETUP_NS = 20;
  localparam int T_RD_PULSE_NS   = 300;
  localparam int T_WR_PULSE_NS   = 300;
  localparam int T_ADDR_HOLD_NS  = 30;
  localparam int T_RECOVER_NS    = 850;
  localparam int T_DEV_RESET_US  = 50;
  localparam int NS_PER_US       = 1000;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic [CNT_W-1:0] AS_LOAD  =
    CNT_W'(ns_to_cyc(T_ADDR_SETUP_NS) - 1);
  localparam logic [CNT_W-1:0] RD_LOAD  =
    CNT_W'(ns_to_cyc(T_RD_PULSE_NS) - 1);
  localparam logic [CNT_W-1:0] WR_LOAD  =
    CNT_W'(ns_to_cyc(T_WR_PULSE_NS) - 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD =
    CNT_W'(ns_to_cyc(T_ADDR_HOLD_NS) - 1);
  localparam logic [CNT_W-1:0] REC_LOAD =
    CNT_W'(ns_to_cyc(T_RECOVER_NS) - 1);
  localparam int DEV_RESET_CYC =
    ns_to_cyc(T_DEV_RESET_US * NS_PER_US);
  localparam int RST_CNT_W = 16;

  // ----------------------------------------------------------------
  // Device address pairs
  // ----------------------------------------------------------------
  localparam logic [1:0] DEV_PORT_A = 2'h0;
  localparam logic [1:0] DEV_PORT_B = 2'h1;
  localparam logic [1:0] DEV_PORT_C = 2'h2;
  localparam logic [1:0] DEV_CTRL   = 2'h3;

  // ----------------------------------------------------------------
  // Avalon register map
  // ----------------------------------------------------------------
  localparam int AVS_ADDR_W = 5;
  localparam logic [4:0] OFS_PORT_A = 5'h00;
  localparam logic [4:0] OFS_PORT_B = 5'h04;
  localparam logic [4:0] OFS_PORT_C = 5'h08;
  localparam logic [4:0] OFS_CTRL   = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_MODE   = 5'h14;
  localparam logic [4:0] OFS_BITCMD = 5'h18;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int CW_MODE_FLAG = 7;
  localparam int CW_A_MODE_HI = 6;
  localparam int CW_A_MODE_LO = 5;
  localparam int CW_DIR_A     = 4;
  localparam int CW_DIR_CU    = 3;
  localparam int CW_MODE_B    = 2;
  localparam int CW_DIR_B     = 1;
  localparam int CW_DIR_CL    = 0;
  localparam int MC_MODE_A    = 5;
  localparam int BC_VAL       = 0;
  localparam int BC_SEL_LO    = 1;
  localparam int BC_SEL_HI    = 3;
  localparam logic [7:0] CW_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int ST_DEV_RESET = 0;
  localparam int ST_IRQ_A     = 1;
  localparam int ST_IRQ_B     = 2;
  localparam int ST_SEQ_BUSY  = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [1:0] addr;
    logic [7:0] dout;
    logic       doe;
  } pin_bus_t;

  typedef struct packed {
    logic       is_read;
    logic [1:0] addr;
    logic [7:0] data;
  } cyc_req_t;

  localparam pin_bus_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                     addr: 2'h0, dout: 8'h00, doe: 1'b0};

  function automatic logic [7:0] mode_word(input logic [7:0] f);
    logic [7:0] w;
    w = 8'h00;
    w[CW_MODE_FLAG] = 1'b1;
    w[CW_A_MODE_HI] = 1'b0;
    w[CW_A_MODE_LO] = f[MC_MODE_A];
    w[CW_DIR_A]     = f[CW_DIR_A];
    w[CW_DIR_CU]    = f[CW_DIR_CU];
    w[CW_MODE_B]    = f[CW_MODE_B];
    w[CW_DIR_B]     = f[CW_DIR_B];
    w[CW_DIR_CL]    = f[CW_DIR_CL];
    return w;
  endfunction

  function automatic logic [7:0] bit_cmd_word(input logic [7:0] f);
    logic [7:0] w;
    w = 8'h00;
    w[BC_SEL_HI:BC_SEL_LO] = f[BC_SEL_HI:BC_SEL_LO];
    w[BC_VAL] = f[BC_VAL];
    return w;
  endfunction

endpackage

// ### hw/pin_cycle.sv
`timescale 1ns/100ps
`default_nettype none

module pin_cycle (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   start,
  input  wire ppi_host_pkg::cyc_req_t req,
  input  wire logic [7:0]             data_in,
  output logic                        ready,
  output logic                        done,
  output logic [7:0]                  rdata,
  output ppi_host_pkg::pin_bus_t      pins
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_SETUP   = 3'b001,
    S_STROBE  = 3'b010,
    S_HOLD    = 3'b011,
    S_RECOVER = 3'b100
  } seq_state_t;

  seq_state_t              state_reg, state_next;
  logic [7:0]              cnt_reg, cnt_next;
  ppi_host_pkg::cyc_req_t  req_reg, req_next;
  logic [7:0]              rdata_reg, rdata_next;
  ppi_host_pkg::pin_bus_t  pins_reg, pins_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg - ppi_host_pkg::CNT_ONE;
    req_next   = req_reg;
    rdata_next = rdata_reg;
    done       = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        cnt_next = ppi_host_pkg::AS_LOAD;
        if (start)
        begin
          req_next   = req;
          state_next = S_SETUP;
        end
      end
      S_SETUP:
        if (cnt_reg == ppi_host_pkg::CNT_ZERO)
        begin
          state_next = S_STROBE;
          cnt_next   = req_reg.is_read ? ppi_host_pkg::RD_LOAD
                                       : ppi_host_pkg::WR_LOAD;
        end
      S_STROBE:
        if (cnt_reg == ppi_host_pkg::CNT_ZERO)
        begin
          // Sampled on the last low cycle, well past access time
          if (req_reg.is_read)
            rdata_next = data_in;
          state_next = S_HOLD;
          cnt_next   = ppi_host_pkg::HOLD_LOAD;
        end
      S_HOLD:
        if (cnt_reg == ppi_host_pkg::CNT_ZERO)
        begin
          done       = 1'b1;
          state_next = S_RECOVER;
          cnt_next   = ppi_host_pkg::REC_LOAD;
        end
      S_RECOVER:
        // Also covers the float time of the device bus after a read
        if (cnt_reg == ppi_host_pkg::CNT_ZERO)
          state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
    pins_next      = ppi_host_pkg::PINS_IDLE;
    pins_next.addr = req_next.addr;
    pins_next.dout = req_next.data;
    if (state_next == S_SETUP || state_next == S_STROBE ||
        state_next == S_HOLD)
    begin
      pins_next.cs_n = 1'b0;
      pins_next.doe  = !req_next.is_read;
      if (state_next == S_STROBE)
      begin
        pins_next.rd_n = !req_next.is_read;
        pins_next.wr_n = req_next.is_read;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= S_IDLE;
      cnt_reg   <= ppi_host_pkg::CNT_ZERO;
      req_reg   <= '0;
      rdata_reg <= 8'h00;
      pins_reg  <= ppi_host_pkg::PINS_IDLE;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      req_reg   <= req_next;
      rdata_reg <= rdata_next;
      pins_reg  <= pins_next;
    end
  end

  assign ready = (state_reg == S_IDLE);
  assign rdata = rdata_reg;
  assign pins  = pins_reg;

endmodule

`default_nettype wire

// ### hw/ppi_host_ctrl.sv
// Notes on behaviour
// - Address 11 write loads control; never read
// - Mode 0 word layout and direction bits
// - Strobed byte reaches bus on host read
// - Peripheral pulls acknowledge low when taken
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ppi_host_ctrl #(
  parameter int DEV_RESET_CYCLES = ppi_host_pkg::DEV_RESET_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             DEV_RESET,
  output logic             DEV_CS_N,
  output logic             DEV_RD_N,
  output logic             DEV_WR_N,
  output logic             PORT_ADDR_BIT0,
  output logic             PORT_ADDR_BIT1,
  input  wire logic [7:0]  DATA_IN,
  output logic [7:0]       DATA_OUT,
  output logic             DATA_OE,
  input  wire logic        IRQ_REQUEST_A,
  input  wire logic        IRQ_REQUEST_B
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_BUSY = 2'b01,
    M_ACK  = 2'b10
  } host_state_t;

  localparam logic [ppi_host_pkg::RST_CNT_W-1:0] RST_LAST =
    ppi_host_pkg::RST_CNT_W'(DEV_RESET_CYCLES - 1);
  localparam logic [ppi_host_pkg::RST_CNT_W-1:0] RST_ONE =
    ppi_host_pkg::RST_CNT_W'(1);

  host_state_t                           state_reg, state_next;
  logic [31:0]                           rdata_reg, rdata_next;
  logic [7:0]                            shadow_reg, shadow_next;
  logic [ppi_host_pkg::RST_CNT_W-1:0]    rst_cnt_reg, rst_cnt_next;
  logic                                  dev_rst_reg, dev_rst_next;
  logic                                  seq_start;
  logic                                  seq_ready;
  logic                                  seq_done;
  logic [7:0]                            seq_rdata;
  ppi_host_pkg::cyc_req_t                seq_req;
  ppi_host_pkg::pin_bus_t                seq_pins;
  logic                                  avs_req;
  logic                                  wr_ok;
  logic [7:0]                            wbyte;
  logic [31:0]                           status_word;

  assign avs_req = AVS_READ || AVS_WRITE;
  assign wr_ok   = AVS_WRITE && AVS_BYTEENABLE[0];
  assign wbyte   = AVS_WRITEDATA[7:0];

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ppi_host_pkg::ST_DEV_RESET] = dev_rst_reg;
    status_word[ppi_host_pkg::ST_IRQ_A]     = IRQ_REQUEST_A;
    status_word[ppi_host_pkg::ST_IRQ_B]     = IRQ_REQUEST_B;
    status_word[ppi_host_pkg::ST_SEQ_BUSY]  = !seq_ready;
  end

  // ----------------------------------------------------------------
  // Device reset stretcher
  // ----------------------------------------------------------------
  always_comb
  begin
    rst_cnt_next = rst_cnt_reg;
    dev_rst_next = dev_rst_reg;
    if (dev_rst_reg)
    begin
      if (rst_cnt_reg == RST_LAST)
        dev_rst_next = 1'b0;
      else
        rst_cnt_next = rst_cnt_reg + RST_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave and command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next  = state_reg;
    rdata_next  = rdata_reg;
    shadow_next = shadow_reg;
    seq_start   = 1'b0;
    seq_req     = '0;
    if (dev_rst_reg)
      shadow_next = ppi_host_pkg::CW_RESET;
    case (state_reg)
      M_IDLE:
        // Held in wait while the device is still in reset
        if (avs_req && !dev_rst_reg)
        begin
          rdata_next = 32'h0000_0000;
          state_next = M_ACK;
          case (AVS_ADDRESS)
            ppi_host_pkg::OFS_PORT_A,
            ppi_host_pkg::OFS_PORT_B,
            ppi_host_pkg::OFS_PORT_C:
            begin
              seq_req.is_read = AVS_READ;
              seq_req.addr    = AVS_ADDRESS[3:2];
              seq_req.data    = wbyte;
              if (AVS_READ || wr_ok)
              begin
                state_next = seq_ready ? M_BUSY : M_IDLE;
                seq_start  = seq_ready;
              end
            end
            ppi_host_pkg::OFS_CTRL:
              if (AVS_READ)
                rdata_next = {24'h00_0000, shadow_reg};
              else if (wr_ok)
              begin
                seq_req.addr = ppi_host_pkg::DEV_CTRL;
                seq_req.data = wbyte;
                state_next   = seq_ready ? M_BUSY : M_IDLE;
                seq_start    = seq_ready;
                if (seq_ready && wbyte[ppi_host_pkg::CW_MODE_FLAG])
                  shadow_next = wbyte;
              end
            ppi_host_pkg::OFS_MODE:
              if (wr_ok)
              begin
                seq_req.addr = ppi_host_pkg::DEV_CTRL;
                seq_req.data = ppi_host_pkg::mode_word(wbyte);
                state_next   = seq_ready ? M_BUSY : M_IDLE;
                seq_start    = seq_ready;
                if (seq_ready)
                  shadow_next = seq_req.data;
              end
            ppi_host_pkg::OFS_BITCMD:
              if (wr_ok)
              begin
                seq_req.addr = ppi_host_pkg::DEV_CTRL;
                seq_req.data = ppi_host_pkg::bit_cmd_word(wbyte);
                state_next   = seq_ready ? M_BUSY : M_IDLE;
                seq_start    = seq_ready;
              end
            ppi_host_pkg::OFS_STATUS:
              rdata_next = status_word;
            default:
              rdata_next = 32'h0000_0000;
          endcase
        end
      M_BUSY:
        if (seq_done)
        begin
          rdata_next = {24'h00_0000, seq_rdata};
          state_next = M_ACK;
        end
      M_ACK:
        state_next = M_IDLE;
      default:
        state_next = M_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      state_reg   <= M_IDLE;
      rdata_reg   <= 32'h0000_0000;
      shadow_reg  <= ppi_host_pkg::CW_RESET;
      rst_cnt_reg <= '0;
      dev_rst_reg <= 1'b1;
    end
    else
    begin
      state_reg   <= state_next;
      rdata_reg   <= rdata_next;
      shadow_reg  <= shadow_next;
      rst_cnt_reg <= rst_cnt_next;
      dev_rst_reg <= dev_rst_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------
  pin_cycle u_pin_cycle (
    .clock   (CLOCK),
    .sys_rst (SYS_RST),
    .start   (seq_start),
    .req     (seq_req),
    .data_in (DATA_IN),
    .ready   (seq_ready),
    .done    (seq_done),
    .rdata   (seq_rdata),
    .pins    (seq_pins)
  );

  assign AVS_WAITREQUEST = avs_req && (state_reg != M_ACK);
  assign AVS_READDATA    = rdata_reg;
  assign DEV_RESET       = dev_rst_reg;
  assign DEV_CS_N        = seq_pins.cs_n;
  assign DEV_RD_N        = seq_pins.rd_n;
  assign DEV_WR_N        = seq_pins.wr_n;
  assign PORT_ADDR_BIT0  = seq_pins.addr[0];
  assign PORT_ADDR_BIT1  = seq_pins.addr[1];
  assign DATA_OUT        = seq_pins.dout;
  assign DATA_OE         = seq_pins.doe;

endmodule

`default_nettype wire

// ### verif/ppi_host_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module ppi_host_ctrl_asserts #(
  parameter int DEV_RESET_CYCLES = 8
) (
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  input  wire logic       DEV_RESET,
  input  wire logic       DEV_CS_N,
  input  wire logic       DEV_RD_N,
  input  wire logic       DEV_WR_N,
  input  wire logic       PORT_ADDR_BIT0,
  input  wire logic       PORT_ADDR_BIT1,
  input  wire logic [7:0] DATA_OUT,
  input  wire logic       DATA_OE
);
  // ----------------------------------------------------------------
  // Strobe width, gap and reset length counters
  // ----------------------------------------------------------------
  logic       strb_n;
  logic [7:0] low_reg;
  logic [7:0] low_next;
  logic [7:0] gap_reg;
  logic [7:0] gap_next;
  int         rst_reg;
  int         rst_next;
  assign strb_n = DEV_RD_N & DEV_WR_N;
  always_comb
  begin
    low_next = strb_n ? 8'h00 : low_reg + 8'h01;
    gap_next = !strb_n ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hFF};
    rst_next = DEV_RESET ? rst_reg + 1 : rst_reg;
  end
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      low_reg <= 8'h00;
      gap_reg <= 8'hFF;
      rst_reg <= 0;
    end
    else
    begin
      low_reg <= low_next;
      gap_reg <= gap_next;
      rst_reg <= rst_next;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  rw_excl_a: assert property (DEV_RD_N | DEV_WR_N)
    else $error("read and write strobes low together");
  no_ctrl_read_a: assert property (!DEV_RD_N |->
    !(PORT_ADDR_BIT1 && PORT_ADDR_BIT0)) else $error("read at address 11");
  select_a: assert property (!strb_n || DATA_OE |-> !DEV_CS_N)
    else $error("strobe or drive without select");
  wdata_hold_a: assert property (!DEV_WR_N |->
    DATA_OE && $stable(DATA_OUT)) else $error("write data moved");
  addr_hold_a: assert property (!DEV_CS_N && !$past(DEV_CS_N) |->
    $stable({PORT_ADDR_BIT1, PORT_ADDR_BIT0})) else $error("address moved");
  setup_a: assert property ($fell(strb_n) |-> !$past(DEV_CS_N, 2))
    else $error("strobe without address setup");
  width_a: assert property ($rose(strb_n) |-> low_reg == 8'h1E)
    else $error("strobe width wrong");
  recover_a: assert property ($fell(strb_n) |-> gap_reg >= 8'h55)
    else $error("strobes too close");
  reset_idle_a: assert property (DEV_RESET |->
    DEV_CS_N && strb_n && !DATA_OE) else $error("access during reset");
  reset_len_a: assert property ($fell(DEV_RESET) |->
    rst_reg >= DEV_RESET_CYCLES - 1) else $error("device reset short");
endmodule

bind ppi_host_ctrl ppi_host_ctrl_asserts #(
  .DEV_RESET_CYCLES(DEV_RESET_CYCLES)
) u_chk (.CLOCK, .SYS_RST, .DEV_RESET, .DEV_CS_N, .DEV_RD_N, .DEV_WR_N,
  .PORT_ADDR_BIT0, .PORT_ADDR_BIT1, .DATA_OUT, .DATA_OE);

`default_nettype wire

// ### verif/ppi_dev_model.sv
`timescale 1ns/100ps
`default_nettype none

module ppi_dev_model (
  input  wire logic       dev_reset,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] bus_wr,
  input  wire logic [7:0] pa_pins,
  input  wire logic [7:0] pb_pins,
  input  wire logic [7:0] pc_pins,
  input  wire logic       strobe_a_n,
  input  wire logic       ack_a_n,
  output logic [7:0]      bus_rd,
  output logic            irq_a
);
  // ----------------------------------------------------------------
  // Edge-driven device; group B handshakes not modelled
  // ----------------------------------------------------------------
  logic [7:0] ctrl, out_a, out_b, out_c, latch_a, last, rd_val;
  logic       irq_enable_ff_a, ibf_a, p_wr, p_rd, p_stb, m1a, m1o, obf_n, p_ack;
  assign m1a = ctrl[6:5] == 2'h1 && ctrl[4];
  assign m1o = ctrl[6:5] == 2'h1 && !ctrl[4];
  always_comb
  begin
    case (addr)
      2'h0: rd_val = m1a ? latch_a : (ctrl[4] ? pa_pins : out_a);
      2'h1: rd_val = ctrl[1] ? pb_pins : out_b;
      default: rd_val = {ctrl[3] ? pc_pins[7:4] : out_c[7:4],
                         ctrl[0] ? pc_pins[3:0] : out_c[3:0]};
    endcase
  end
  // Released bus shows the inverse so a stale value never passes
  assign bus_rd = (!cs_n && !rd_n && addr != 2'h3) ? rd_val : ~last;
  always @(wr_n or rd_n or strobe_a_n or ack_a_n or dev_reset)
  begin
    if (dev_reset)
    begin
      ctrl = 8'h9B;
      out_a = 8'h00;
      out_c = 8'h00;
      irq_enable_ff_a = 1'b0;
      ibf_a = 1'b0;
      irq_a = 1'b0;
      last = 8'h00;
      obf_n = 1'b1;
    end
    else
    begin
      if (!cs_n && wr_n && !p_wr)
        case (addr)
          2'h0: out_a = bus_wr;
          2'h1: out_b = bus_wr;
          2'h2: out_c = bus_wr;
          default:
            if (bus_wr[7])
            begin
              ctrl = bus_wr;
              out_a = 8'h00;
              out_c = 8'h00;
              out_b = ~out_b;
            end
            else
            begin
              out_c[bus_wr[3:1]] = bus_wr[0];
              if (bus_wr[3:1] == (ctrl[4] ? 3'h4 : 3'h6))
                irq_enable_ff_a = bus_wr[0];
            end
        endcase
      if (!cs_n && addr == 2'h0 && rd_n && !p_rd && m1a)
        ibf_a = 1'b0;
      if (!cs_n && addr == 2'h0 && !rd_n && p_rd)
        irq_a = 1'b0;
      if (!p_rd && rd_n)
        last = rd_val;
      if (m1a && !strobe_a_n && p_stb)
      begin
        latch_a = pa_pins;
        ibf_a = 1'b1;
      end
      if (m1a && strobe_a_n && !p_stb)
        irq_a = ibf_a && irq_enable_ff_a;
      if (!cs_n && addr == 2'h0 && wr_n && !p_wr && m1o)
        obf_n = 1'b0;
      if (!cs_n && addr == 2'h0 && !wr_n && p_wr && m1o)
        irq_a = 1'b0;
      if (m1o && !ack_a_n && p_ack)
        obf_n = 1'b1;
      if (m1o && ack_a_n && !p_ack)
        irq_a = obf_n && irq_enable_ff_a;
    end
    p_ack = ack_a_n;
    p_wr = wr_n;
    p_rd = rd_n;
    p_stb = strobe_a_n;
  end
endmodule

`default_nettype wire

// ### verif/ppi_host_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
      num_errors++; \
    end \
  end

module ppi_host_ctrl_test;
  logic        CLOCK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [4:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, d;
  logic [3:0]  AVS_BYTEENABLE;
  logic        DEV_RESET, DEV_CS_N, DEV_RD_N, DEV_WR_N, DATA_OE, irq_a, stb;
  logic        PORT_ADDR_BIT0, PORT_ADDR_BIT1, ack, irq_b;
  logic [7:0]  DATA_IN, DATA_OUT, dev_q, pa, pb, pc;
  int          num_errors, check_count, i;
  assign DATA_IN = DATA_OE ? DATA_OUT : dev_q;
  ppi_host_ctrl #(.DEV_RESET_CYCLES(8)) u_dut (.CLOCK, .SYS_RST,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
    .AVS_READDATA, .AVS_WAITREQUEST, .DEV_RESET, .DEV_CS_N, .DEV_RD_N,
    .DEV_WR_N, .PORT_ADDR_BIT0, .PORT_ADDR_BIT1, .DATA_IN, .DATA_OUT,
    .DATA_OE, .IRQ_REQUEST_A(irq_a), .IRQ_REQUEST_B(irq_b));
  ppi_dev_model u_dev (.dev_reset(DEV_RESET), .cs_n(DEV_CS_N),
    .rd_n(DEV_RD_N), .wr_n(DEV_WR_N), .addr({PORT_ADDR_BIT1, PORT_ADDR_BIT0}),
    .bus_wr(DATA_OUT), .pa_pins(pa), .pb_pins(pb), .pc_pins(pc),
    .strobe_a_n(stb), .ack_a_n(ack), .bus_rd(dev_q), .irq_a(irq_a));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] v,
                    input logic [3:0] be);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h000000, v};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= 1'b1;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, string nm);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_READ <= 1'b1;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    d = AVS_READDATA;
    AVS_READ <= 1'b0;
    // Busy bit depends on recovery timing, so status is masked
    if (a == ppi_host_pkg::OFS_STATUS)
      d = d & 32'h00000007;
    `CHK(nm, {24'h000000, e}, d)
  endtask
  task automatic strobe(input logic [7:0] v);
    pa <= v;
    // Port data settles before the falling strobe latches it
    @(posedge CLOCK);
    stb <= 1'b0;
    repeat (40) @(posedge CLOCK);
    stb <= 1'b1;
    @(posedge CLOCK);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  initial
  begin
    repeat (60000) @(posedge CLOCK);
    num_errors++;
    complete_run;
  end
  initial
  begin
    {SYS_RST, stb, ack, irq_b} = 4'hE;
    {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    AVS_BYTEENABLE = 4'h0;
    {pa, pb, pc} = 24'hC3_5A_96;
    num_errors = 0;
    check_count = 0;
    repeat (4) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    `CHK("device reset", 1'b1, DEV_RESET)
    rd(ppi_host_pkg::OFS_STATUS, 8'h00, "status");
    rd(ppi_host_pkg::OFS_CTRL, ppi_host_pkg::CW_RESET, "shadow");
    rd(ppi_host_pkg::OFS_PORT_A, 8'hC3, "reset input");
    $display("test reset done");
    wr(ppi_host_pkg::OFS_MODE, 8'h00, 4'h1);
    rd(ppi_host_pkg::OFS_CTRL, 8'h80, "mode word");
    for (i = 0; i < 3; i++)
      wr(5'(4 * i), 8'h3C ^ 8'(i * 8'h47), 4'h1);
    for (i = 0; i < 3; i++)
      rd(5'(4 * i), 8'h3C ^ 8'(i * 8'h47), "port out");
    wr(ppi_host_pkg::OFS_PORT_A, 8'hFF, 4'h0);
    rd(ppi_host_pkg::OFS_PORT_A, 8'h3C, "byte off");
    rd(5'h1C, 8'h00, "unmapped");
    wr(ppi_host_pkg::OFS_CTRL, 8'h80, 4'h1);
    rd(ppi_host_pkg::OFS_PORT_A, 8'h00, "a cleared");
    rd(ppi_host_pkg::OFS_PORT_C, 8'h00, "c cleared");
    $display("test mode 0 output done");
    for (i = 0; i < 8; i++)
    begin
      wr(ppi_host_pkg::OFS_BITCMD, {4'h0, 3'(i), 1'b1}, 4'h1);
      rd(ppi_host_pkg::OFS_PORT_C, 8'((16'h2 << i) - 1), "set");
    end
    for (i = 0; i < 8; i++)
    begin
      wr(ppi_host_pkg::OFS_BITCMD, {4'h0, 3'(i), 1'b0}, 4'h1);
      rd(ppi_host_pkg::OFS_PORT_C, 8'hFF << (i + 1), "clear");
    end
    $display("test bit commands done");
    wr(ppi_host_pkg::OFS_MODE, 8'h1B, 4'h1);
    rd(ppi_host_pkg::OFS_CTRL, 8'h9B, "input word");
    for (i = 0; i < 3; i++)
      rd(5'(4 * i), {pa, pb, pc} >> (16 - 8 * i), "port in");
    pa <= 8'hA5;
    rd(ppi_host_pkg::OFS_PORT_A, 8'hA5, "unlatched");
    $display("test mode 0 input done");
    wr(ppi_host_pkg::OFS_MODE, 8'h30, 4'h1);
    rd(ppi_host_pkg::OFS_CTRL, 8'hB0, "strobed word");
    wr(ppi_host_pkg::OFS_BITCMD, 8'h09, 4'h1);
    strobe(8'h6E);
    pa <= 8'h11;
    rd(ppi_host_pkg::OFS_STATUS, 8'h02, "irq raised");
    rd(ppi_host_pkg::OFS_PORT_A, 8'h6E, "latched");
    rd(ppi_host_pkg::OFS_STATUS, 8'h00, "irq dropped");
    wr(ppi_host_pkg::OFS_BITCMD, 8'h08, 4'h1);
    strobe(8'h77);
    rd(ppi_host_pkg::OFS_STATUS, 8'h00, "irq masked");
    $display("test strobed input done");
    wr(ppi_host_pkg::OFS_MODE, 8'h20, 4'h1);
    rd(ppi_host_pkg::OFS_CTRL, 8'hA0, "output word");
    wr(ppi_host_pkg::OFS_BITCMD, 8'h0D, 4'h1);
    wr(ppi_host_pkg::OFS_PORT_A, 8'h5A, 4'h1);
    rd(ppi_host_pkg::OFS_STATUS, 8'h00, "no ack irq");
    ack <= 1'b0;
    repeat (40) @(posedge CLOCK);
    ack <= 1'b1;
    @(posedge CLOCK);
    rd(ppi_host_pkg::OFS_STATUS, 8'h02, "ack irq");
    wr(ppi_host_pkg::OFS_PORT_A, 8'h33, 4'h1);
    rd(ppi_host_pkg::OFS_STATUS, 8'h00, "write irq");
    rd(ppi_host_pkg::OFS_PORT_A, 8'h33, "output latch");
    irq_b <= 1'b1;
    rd(ppi_host_pkg::OFS_STATUS, 8'h04, "irq b");
    $display("test strobed output done");
    complete_run;
  end
endmodule

`default_nettype wire
